/* hdl/idad_pkg.sv */
// idad_pkg: constants and types for the dual-target i2c access decoder
// assumes a single 20 MHz clock domain
`default_nettype none
package idad_pkg;
   localparam logic [5:0]  IDAD_PORT_PREFIX  = 6'h10;   // 010000 above the fixed pin
   localparam logic [5:0]  IDAD_EE_PREFIX    = 6'h28;   // 101000 above the fixed pin
   localparam int          IDAD_SOFT_PINS    = 6;
   localparam int          IDAD_EE_AW        = 15;
   localparam logic [14:0] IDAD_EE_LAST      = 15'h6FFF; // end of eeprom space
   localparam logic [14:0] IDAD_USER_LAST    = 15'h6BFF; // end of user data region
   localparam logic [5:0]  IDAD_PAGE_MASK    = 6'h3F;    // 64-byte page
   localparam int          IDAD_PROG_NS      = 5000;
   localparam int          IDAD_CLK_NS       = 50;
   localparam int          IDAD_PROG_CYC     = (IDAD_PROG_NS + IDAD_CLK_NS - 1) / IDAD_CLK_NS;
   localparam logic [2:0]  IDAD_SOFT_CNT_RST = 3'h0;

   typedef enum logic [6:0] {
      IDAD_IDLE  = 7'b0000001,
      IDAD_ADDR  = 7'b0000010,
      IDAD_FIRST = 7'b0000100,
      IDAD_ALO   = 7'b0001000,
      IDAD_WDATA = 7'b0010000,
      IDAD_RDATA = 7'b0100000,
      IDAD_PORT  = 7'b1000000
   } idad_state_t;
endpackage
`default_nettype wire

/* hdl/idad_bit_if.sv */
// idad_bit_if: byte-level link between the bit engine and the decoder
// assumes one clock; all strobes are single-cycle
`timescale 1ns/1ps
`default_nettype none
interface idad_bit_if;
   logic       start;     // start or repeated start seen
   logic       stop;
   logic       byte_vld;  // byte received, awaiting ack decision
   logic [7:0] rx_byte;
   logic       ack_req;   // need tx byte for read
   logic       master_ack;
   logic       ack_en;    // decoder decision: acknowledge
   logic       ack_dec;   // decision strobe
   logic [7:0] tx_byte;
   logic       tx_load;
   logic       hold_scl;  // stretch the clock
   modport engine  (output start, stop, byte_vld, rx_byte, ack_req, master_ack,
                    input ack_en, ack_dec, tx_byte, tx_load, hold_scl);
   modport decoder (input start, stop, byte_vld, rx_byte, ack_req, master_ack,
                    output ack_en, ack_dec, tx_byte, tx_load, hold_scl);
endinterface
`default_nettype wire

/* hdl/idad_bit_engine.sv */
// idad_bit_engine: i2c target bit layer with clock stretching
// assumes synchronised scl/sda levels from the top
`timescale 1ns/1ps
`default_nettype none
module idad_bit_engine
   import idad_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // synchronised bus levels
   input  wire logic scl_s,
   input  wire logic sda_s,
   // drive requests, high means pull low
   output logic      sda_low_q,
   output logic      scl_low_q,
   // decoder side
   idad_bit_if.engine bi
);
   logic       scl_d1_q, sda_d1_q, rd_q, active_q, ack_ph_q, wait_q, go_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   wire rise  = scl_s & ~scl_d1_q;
   wire fall  = ~scl_s & scl_d1_q;
   wire start = scl_s & sda_d1_q & ~sda_s;
   wire stop  = scl_s & ~sda_d1_q & sda_s;

   assign bi.start   = start;
   assign bi.stop    = stop;
   assign bi.rx_byte = sh_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         {scl_d1_q, sda_d1_q} <= 2'h3;
         {rd_q, active_q, ack_ph_q, wait_q, go_q, sda_low_q, scl_low_q} <= 7'h0;
         cnt_q <= 4'h0;
         sh_q  <= 8'h0;
         bi.byte_vld <= 1'b0;
         bi.ack_req <= 1'b0;
         bi.master_ack <= 1'b0;
      end
      else
      begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
         bi.byte_vld <= 1'b0;
         bi.ack_req <= 1'b0;
         // decision arrives with the byte strobe, so no stretch pulse per byte
         scl_low_q <= bi.hold_scl | (wait_q & ~bi.ack_dec);
         if (start | stop)
         begin
            active_q <= start;
            cnt_q <= 4'h0;
            ack_ph_q <= 1'b0;
            rd_q <= 1'b0;
            wait_q <= 1'b0;
            go_q <= 1'b0;
            sda_low_q <= 1'b0;
            bi.master_ack <= 1'b0;
         end
         else if (active_q)
         begin
            if (bi.ack_dec)
            begin
               wait_q <= 1'b0;
               sda_low_q <= bi.ack_en;
               if (!bi.ack_en)
                  active_q <= 1'b0;
            end
            if (rise & !ack_ph_q)
            begin
               if (!rd_q)
                  sh_q <= {sh_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end
            else if (rise & ack_ph_q & rd_q & !go_q)
               bi.master_ack <= ~sda_s;
            if (fall)
            begin
               if (!ack_ph_q && cnt_q == 4'h8)
               begin
                  ack_ph_q <= 1'b1;
                  if (rd_q)
                     sda_low_q <= 1'b0;
                  else
                  begin
                     bi.byte_vld <= 1'b1;
                     wait_q <= 1'b1;
                  end
               end
               else if (ack_ph_q)
               begin
                  ack_ph_q <= 1'b0;
                  cnt_q <= 4'h0;
                  if (go_q)
                  begin
                     // first read byte starts right after the address ack
                     go_q <= 1'b0;
                     sda_low_q <= ~sh_q[7];
                     sh_q <= {sh_q[6:0], 1'b1};
                  end
                  else
                  begin
                     sda_low_q <= 1'b0;
                     if (rd_q)
                        bi.ack_req <= 1'b1;
                  end
               end
               else if (rd_q)
               begin
                  sda_low_q <= ~sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b1};
               end
            end
            if (bi.tx_load)
            begin
               rd_q <= 1'b1;
               if (bi.ack_dec)
               begin
                  sh_q <= bi.tx_byte;
                  go_q <= 1'b1;
               end
               else
               begin
                  sda_low_q <= ~bi.tx_byte[7];
                  sh_q <= {bi.tx_byte[6:0], 1'b1};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* hdl/idad_top.sv */
// idad_top: dual-target i2c access decoder (port device + eeprom)
// assumes external sram-like eeprom and register ports on ref_clk
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: with no soft pins the targets are 010000p and 101000p, p the fixed pin.
// RL2: each soft pin in use replaces the next higher prefix bit from bit one upward.
// RL3: with all six pins in use the top bit of the first written byte picks port or eeprom.
// RL4: in that case the top bit is cleared before use as the high eeprom address.
// RL5: eeprom accesses take a high then a low address byte into the address counter.
// RL6: the master reads by writing the address, re-addressing for read, then clocking bytes.
// RL7: each eeprom byte returned advances the counter up to the last location.
// RL8: accesses past the end are nacked, and so is every write byte after the end.
// RL9: the master writes address bytes and data in one write transaction.
// RL10: unaligned write start addresses are accepted.
// RL11: crossing a 64-byte boundary in a write holds scl low while the page is programmed.
// RL12: the first port-device byte is the register pointer for following data.
// RL13: the write-block input high blocks eeprom writes to the user data region.
// RL14: unmatched addresses get no ack, and address bit zero is the direction.
// RL15: each accepted eeprom write byte below the last location advances the counter by one.
module idad_top
   import idad_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // i2c pins, enable low while driving low
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   // address straps
   input  wire logic        fixed_target_addr_pin,
   input  wire logic [5:0]  soft_target_addr_pins,
   input  wire logic [2:0]  soft_pin_count,
   input  wire logic        eeprom_write_block_input,
   // eeprom port
   output logic [14:0]      ee_addr_q,
   output logic             ee_wr_q,
   output logic [7:0]       ee_wdata_q,
   output logic             ee_commit_q,
   input  wire logic [7:0]  ee_rdata,
   // port-device register port
   output logic [7:0]       reg_ptr_q,
   output logic             reg_wr_q,
   output logic             reg_rd_q,
   output logic [7:0]       reg_wdata_q,
   input  wire logic [7:0]  reg_rdata
);
   idad_bit_if bi ();
   logic [1:0]  scl_sy_q, sda_sy_q, wb_sy_q, a0_sy_q;
   logic [5:0]  soft_m_q, soft_s_q;
   logic        sda_low, scl_low;
   idad_state_t st_q;
   logic        ee_sel_q, rd_q, end_q, page_q, page_cross_q;
   logic        ld_q, ee_inc_q, reg_inc_q;
   logic [12:0] prog_q;

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         {scl_sy_q, sda_sy_q, wb_sy_q, a0_sy_q} <= 8'hFF;
         soft_m_q <= 6'h0;
         soft_s_q <= 6'h0;
      end
      else
      begin
         scl_sy_q <= {scl_sy_q[0], scl_in};
         sda_sy_q <= {sda_sy_q[0], sda_in};
         wb_sy_q  <= {wb_sy_q[0], eeprom_write_block_input};
         a0_sy_q  <= {a0_sy_q[0], fixed_target_addr_pin};
         soft_m_q <= soft_target_addr_pins;
         soft_s_q <= soft_m_q;
      end
   end

   idad_bit_engine u_eng (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .scl_s     (scl_sy_q[1]),
      .sda_s     (sda_sy_q[1]),
      .sda_low_q (sda_low),
      .scl_low_q (scl_low),
      .bi        (bi)
   );

   ////////////////////////////////////////////////////////////////
   // address build
   function automatic logic [6:0] tgt(input logic [5:0] pre, input logic [5:0] pins,
                                      input logic [2:0] n, input logic a0);
      logic [5:0] m;
      m = 6'h0;
      for (int i = 0; i < IDAD_SOFT_PINS; i++)
         m[i] = (i < int'(n));
      return {(pre & ~m) | (pins & m), a0};
   endfunction

   wire        all_pins  = (soft_pin_count >= 3'h6);
   wire [6:0]  port_addr = tgt(IDAD_PORT_PREFIX, soft_s_q, soft_pin_count, a0_sy_q[1]); // RL1 RL2
   wire [6:0]  ee_addr7  = tgt(IDAD_EE_PREFIX, soft_s_q, soft_pin_count, a0_sy_q[1]);   // RL1 RL2
   wire [7:0]  rxb       = bi.rx_byte;
   wire        hit_port  = (rxb[7:1] == port_addr);
   wire        hit_ee    = (rxb[7:1] == ee_addr7) & ~all_pins;
   wire        hit       = all_pins ? hit_port : (hit_port | hit_ee); // RL14
   wire        is_rd     = rxb[0]; // RL14
   wire        at_end    = (ee_addr_q == IDAD_EE_LAST);
   wire        wr_block  = wb_sy_q[1] & (ee_addr_q <= IDAD_USER_LAST); // RL13
   wire        wr_ok     = ~end_q & ~wr_block & (ee_addr_q <= IDAD_EE_LAST);
   wire        prog_busy = (prog_q != 13'h0);

   assign bi.hold_scl = prog_busy; // RL11
   assign bi.ack_dec  = bi.byte_vld & (st_q != IDAD_IDLE);
   assign bi.ack_en   = (st_q == IDAD_ADDR)  ? hit :
                        (st_q == IDAD_WDATA) ? wr_ok : // RL8
                        (st_q == IDAD_FIRST) ? (~(ee_sel_q | (all_pins & rxb[7]))
                                                | (rxb[6:0] <= IDAD_EE_LAST[14:8])) : 1'b1; // RL8
   assign bi.tx_byte  = ee_sel_q ? ee_rdata : reg_rdata;
   // later bytes load one cycle after the counter step
   assign bi.tx_load  = (bi.byte_vld & st_q == IDAD_ADDR & hit & is_rd) | ld_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         st_q <= IDAD_IDLE;
         {ee_sel_q, rd_q, end_q, page_q, page_cross_q} <= 5'h0;
         {ee_wr_q, ee_commit_q, reg_wr_q, reg_rd_q} <= 4'h0;
         ee_addr_q <= 15'h0;
         ee_wdata_q <= 8'h0;
         reg_ptr_q <= 8'h0;
         reg_wdata_q <= 8'h0;
         prog_q <= 13'h0;
         {ld_q, ee_inc_q, reg_inc_q} <= 3'h0;
      end
      else
      begin
         {ee_wr_q, ee_commit_q, reg_wr_q, reg_rd_q} <= 4'h0;
         ld_q <= bi.ack_req & bi.master_ack & (st_q == IDAD_RDATA);
         {ee_inc_q, reg_inc_q} <= 2'h0;
         // step after the strobe so address stands with its data
         if (ee_inc_q)
            ee_addr_q <= ee_addr_q + 15'h1; // RL15
         if (reg_inc_q)
            reg_ptr_q <= reg_ptr_q + 8'h1;
         if (prog_busy)
            prog_q <= prog_q - 13'h1;
         if (bi.start)
            st_q <= IDAD_ADDR;
         else if (bi.stop)
         begin
            st_q <= IDAD_IDLE;
            if (page_q)
            begin
               ee_commit_q <= 1'b1;
               page_q <= 1'b0;
            end
         end
         else if (bi.byte_vld)
         begin
            case (st_q)
               IDAD_ADDR:
               begin
                  rd_q <= is_rd;
                  if (!hit)
                     st_q <= IDAD_IDLE;
                  else if (is_rd)
                  begin
                     st_q <= IDAD_RDATA; // RL6
                     reg_rd_q <= ~ee_sel_q;
                  end
                  else
                  begin
                     ee_sel_q <= hit_ee;
                     st_q <= IDAD_FIRST; // RL12
                  end
               end
               IDAD_FIRST:
                  if (ee_sel_q | (all_pins & rxb[7])) // RL3
                  begin
                     ee_sel_q <= 1'b1;
                     ee_addr_q[14:8] <= rxb[6:0]; // RL4 RL5
                     st_q <= IDAD_ALO;
                  end
                  else
                  begin
                     ee_sel_q <= 1'b0;
                     reg_ptr_q <= rxb; // RL12
                     st_q <= IDAD_PORT;
                  end
               IDAD_ALO:
               begin
                  ee_addr_q[7:0] <= rxb; // RL5
                  end_q <= 1'b0;
                  st_q <= IDAD_WDATA; // RL9 RL10
               end
               IDAD_WDATA:
                  if (wr_ok)
                  begin
                     ee_wr_q <= 1'b1;
                     ee_wdata_q <= rxb;
                     page_q <= 1'b1;
                     if (at_end)
                        end_q <= 1'b1; // RL8
                     else
                        ee_inc_q <= 1'b1; // RL15
                     if ((ee_addr_q[5:0] & IDAD_PAGE_MASK) == IDAD_PAGE_MASK)
                     begin
                        ee_commit_q <= 1'b1; // RL11
                        page_q <= 1'b0;
                        prog_q <= 13'(IDAD_PROG_CYC);
                     end
                  end
               IDAD_PORT:
               begin
                  reg_wr_q <= 1'b1;
                  reg_wdata_q <= rxb;
                  reg_inc_q <= 1'b1;
               end
               default:
                  st_q <= IDAD_IDLE;
            endcase
         end
         else if (bi.ack_req & st_q == IDAD_RDATA)
         begin
            if (ee_sel_q & ~at_end)
               ee_addr_q <= ee_addr_q + 15'h1; // RL7
            else if (!ee_sel_q)
            begin
               reg_ptr_q <= reg_ptr_q + 8'h1;
               reg_rd_q <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end
      else
      begin
         scl_oe_n <= ~scl_low;
         sda_oe_n <= ~sda_low;
      end
   end
endmodule
`default_nettype wire

/* testbench/idad_props.sv */
// idad_props: port checks for the dual-target access decoder
// assumes bind into idad_top, one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module idad_props
   import idad_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // bus side
   input  wire logic        scl_in,
   input  wire logic        scl_out,
   input  wire logic        scl_oe_n,
   input  wire logic        sda_out,
   input  wire logic        sda_oe_n,
   // memory side
   input  wire logic        eeprom_write_block_input,
   input  wire logic [14:0] ee_addr_q,
   input  wire logic        ee_wr_q,
   input  wire logic        ee_commit_q,
   input  wire logic        reg_wr_q,
   input  wire logic        reg_rd_q
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [14:0] last_wr_q;
   logic [7:0]  low_cnt_q;
   always_ff @(posedge ref_clk)
   begin
      if (ee_wr_q)
         last_wr_q <= ee_addr_q;
      low_cnt_q <= (scl_oe_n || !rstn) ? 8'h00 : low_cnt_q + 8'h01;
   end
   ////////////////////////////////////////
   a_wr_pulse: assert property (ee_wr_q |=> !ee_wr_q)
      else $error("eeprom write strobe too long");
   a_addr_step: assert property (ee_wr_q && ee_addr_q != IDAD_EE_LAST
      |=> ##[0:40] ee_addr_q == last_wr_q + 15'h0001) else $error("eeprom address did not advance");
   a_no_past_end: assert property (ee_wr_q |-> ee_addr_q <= IDAD_EE_LAST)
      else $error("write beyond eeprom space");
   a_block_user: assert property (eeprom_write_block_input && ee_addr_q <= IDAD_USER_LAST |-> !ee_wr_q)
      else $error("blocked write reached eeprom");
   a_page_commit: assert property (ee_wr_q && ee_addr_q[5:0] == IDAD_PAGE_MASK |-> ##[0:60] ee_commit_q)
      else $error("no page commit at boundary");
   a_commit_pulse: assert property (ee_commit_q |=> !ee_commit_q)
      else $error("commit strobe too long");
   a_stretch_len: assert property ($rose(scl_oe_n) |-> low_cnt_q >= 8'(IDAD_PROG_CYC - 2)
      && low_cnt_q <= 8'(IDAD_PROG_CYC + 2)) else $error("clock stretch length wrong");
   a_reg_strobe: assert property (reg_wr_q || reg_rd_q |=> !reg_wr_q && !reg_rd_q)
      else $error("register strobe too long");
   a_sda_low_phase: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data line moved while clock high");
   a_open_drain: assert property (!scl_out && !sda_out)
      else $error("bus pin driven high");
   c_commit: cover property (ee_commit_q);
   c_stretch: cover property ($rose(scl_oe_n));
   c_reg_wr: cover property (reg_wr_q);
endmodule
bind idad_top idad_props u_props (.ref_clk, .rstn, .scl_in, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n,
   .eeprom_write_block_input, .ee_addr_q, .ee_wr_q, .ee_commit_q, .reg_wr_q, .reg_rd_q);
`default_nettype wire

/* testbench/idad_i2c_master.sv */
// idad_i2c_master: behavioural i2c bus master that honours clock stretching
// assumes open-drain wiring in the bench; high on scl_m/sda_m releases the line
`timescale 1ns/1ps
`default_nettype none
module idad_i2c_master
(
   // clock and bus levels
   input  wire logic ref_clk,
   input  wire logic scl,
   input  wire logic sda,
   // line drive and stall flag
   output logic      scl_m,
   output logic      sda_m,
   output logic      hang
);
   localparam int H = 20;
   initial
   begin
      scl_m = 1'h1;
      sda_m = 1'h1;
      hang = 1'h0;
   end
   ////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // release clock, wait out a stretch
   task automatic rise();
      scl_m = 1'h1;
      for (int i = 0; i < 400 && scl !== 1'h1; i++) tick(1);
      if (scl !== 1'h1) hang = 1'h1;
      tick(H);
   endtask
   task automatic bt(input logic v, output logic s);
      sda_m = v;
      tick(H);
      rise();
      s = sda;
      scl_m = 1'h0;
      tick(4);
   endtask
   task automatic start();
      sda_m = 1'h1;
      tick(H);
      rise();
      sda_m = 1'h0;
      tick(H);
      scl_m = 1'h0;
      tick(4);
   endtask
   task automatic stop();
      sda_m = 1'h0;
      tick(H);
      rise();
      sda_m = 1'h1;
      tick(H);
   endtask
   task automatic wb(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bt(b[i], s);
      bt(1'h1, s);
      ack = ~s;
   endtask
   task automatic rb(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bt(1'h1, s);
         b[i] = s;
      end
      bt(last, s);
   endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// testbench: drives the access decoder through the i2c master model
// assumes idad_i2c_master on the bus; memory answers are modelled here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %0t %h vs %h", $time, g, e); end end
module testbench
   import idad_pkg::*;
;
   logic        ref_clk, rstn, a0, wblk, scl_m, sda_m, hang, scl_oe_n, sda_oe_n;
   logic        ee_wr_q, ee_commit_q, reg_wr_q, reg_rd_q;
   logic [5:0]  pins;
   logic [2:0]  npin;
   logic [14:0] ee_addr_q;
   logic [7:0]  ee_wdata_q, reg_ptr_q, reg_wdata_q, d;
   wire  logic  scl, sda;
   wire  logic [7:0] ee_rdata, reg_rdata;
   logic [22:0] wrq[$];
   logic [15:0] regq[$];
   int          n_commit = 0, n_str = 0, miscompares = 0, n_tests = 0;
   assign scl = scl_m & (scl_oe_n !== 1'h0);
   assign sda = sda_m & (sda_oe_n !== 1'h0);
   assign ee_rdata = ee_addr_q[7:0] ^ 8'hA5;
   assign reg_rdata = reg_ptr_q ^ 8'h3C;
   idad_top u_dut (.ref_clk, .rstn, .scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(), .sda_oe_n,
      .fixed_target_addr_pin(a0), .soft_target_addr_pins(pins), .soft_pin_count(npin),
      .eeprom_write_block_input(wblk), .ee_addr_q, .ee_wr_q, .ee_wdata_q, .ee_commit_q, .ee_rdata,
      .reg_ptr_q, .reg_wr_q, .reg_rd_q, .reg_wdata_q, .reg_rdata);
   idad_i2c_master u_m (.ref_clk, .scl, .sda, .scl_m, .sda_m, .hang);
   ////////////////////////////////////////
   always @(posedge ref_clk)
   begin
      if (ee_wr_q) wrq.push_back({ee_addr_q, ee_wdata_q});
      if (reg_wr_q) regq.push_back({reg_ptr_q, reg_wdata_q});
      if (ee_commit_q) n_commit++;
      if (!scl_oe_n) n_str++;
   end
   task automatic complete_run();
      if (miscompares == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wa(input logic [7:0] b, input logic e);
      logic k;
      u_m.wb(b, k);
      `CHK(k, e)
   endtask
   task automatic probe(input logic [6:0] a, input logic e);
      u_m.start();
      wa({a, 1'h0}, e);
      u_m.stop();
   endtask
   task automatic t_addr();
      logic [5:0] m;
      for (int n = 0; n <= 5; n++)
      begin
         npin = 3'(n);
         a0 = n[0];
         pins = 6'h2A;
         m = 6'h3F >> (6 - n);
         probe({(IDAD_PORT_PREFIX & ~m) | (pins & m), a0}, 1'h1);
         probe({(IDAD_EE_PREFIX & ~m) | (pins & m), a0}, 1'h1);
         probe({(IDAD_PORT_PREFIX & ~m) | (pins & m), ~a0}, 1'h0);
      end
   endtask
   task automatic t_ee_wr();
      int c, s;
      npin = 3'h0;
      a0 = 1'h0;
      wrq.delete();
      c = n_commit;
      s = n_str;
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h0}, 1'h1);
      wa(8'h00, 1'h1);
      wa(8'h3E, 1'h1);
      for (int i = 0; i < 3; i++) wa(8'h60 + 8'(i), 1'h1);
      u_m.stop();
      `CHK(wrq.size(), 3)
      for (int i = 0; i < 3; i++) `CHK(wrq[i], {15'h003E + 15'(i), 8'h60 + 8'(i)})
      `CHK(n_commit - c, 2)
      `CHK((n_str - s) inside {[IDAD_PROG_CYC - 2:IDAD_PROG_CYC + 2]}, 1'h1)
   endtask
   task automatic t_ee_rd();
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h0}, 1'h1);
      wa(8'h01, 1'h1);
      wa(8'h23, 1'h1);
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h1}, 1'h1);
      for (int i = 0; i < 3; i++)
      begin
         u_m.rb(i == 2, d);
         `CHK(d, (8'h23 + 8'(i)) ^ 8'hA5)
      end
      u_m.stop();
   endtask
   task automatic t_ee_end();
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h0}, 1'h1);
      wa(8'h6F, 1'h1);
      wa(8'hFF, 1'h1);
      wa(8'h11, 1'h1);
      wa(8'h22, 1'h0);
      u_m.stop();
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h0}, 1'h1);
      wa(8'h70, 1'h0);
      u_m.stop();
      wblk = 1'h1;
      wrq.delete();
      u_m.start();
      wa({IDAD_EE_PREFIX, 2'h0}, 1'h1);
      wa(8'h00, 1'h1);
      wa(8'h10, 1'h1);
      wa(8'h33, 1'h0);
      u_m.stop();
      wblk = 1'h0;
      `CHK(wrq.size(), 0)
   endtask
   task automatic t_all();
      npin = 3'h6;
      pins = 6'h15;
      a0 = 1'h1;
      wrq.delete();
      regq.delete();
      u_m.start();
      wa(8'h56, 1'h1);
      wa(8'h05, 1'h1);
      wa(8'h77, 1'h1);
      u_m.stop();
      `CHK(regq[0], {8'h05, 8'h77})
      u_m.start();
      wa(8'h56, 1'h1);
      wa(8'h81, 1'h1);
      wa(8'h02, 1'h1);
      wa(8'h44, 1'h1);
      u_m.stop();
      `CHK(wrq[0], {15'h0102, 8'h44})
   endtask
   task automatic t_port_rd();
      npin = 3'h0;
      a0 = 1'h0;
      u_m.start();
      wa({IDAD_PORT_PREFIX, 2'h0}, 1'h1);
      wa(8'h12, 1'h1);
      u_m.start();
      wa({IDAD_PORT_PREFIX, 2'h1}, 1'h1);
      u_m.rb(1'h1, d);
      u_m.stop();
      `CHK(d, 8'h12 ^ 8'h3C)
   endtask
   initial
   begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      miscompares++;
      complete_run();
   end
   always @(posedge hang)
   begin
      miscompares++;
      complete_run();
   end
   initial
   begin
      {rstn, a0, wblk, pins, npin} = 11'h000;
      repeat (20) @(posedge ref_clk);
      #1;
      rstn = 1'h1;
      repeat (3) @(posedge ref_clk);
      #1;
      t_addr();
      t_ee_wr();
      t_ee_rd();
      t_ee_end();
      t_all();
      t_port_rd();
      complete_run();
   end
endmodule
`default_nettype wire
